// [hw/ssop_pkg.sv]
package ssop_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CONFIG        = 8'h00;
  localparam logic [7:0] OFS_MON_TIME      = 8'h04;
  localparam logic [7:0] OFS_MON_DELAY     = 8'h08;
  localparam logic [7:0] OFS_STOP_SPEED    = 8'h0c;
  localparam logic [7:0] OFS_DETECT_DELAY  = 8'h10;
  localparam logic [7:0] OFS_ENV_TC        = 8'h14;
  localparam logic [7:0] OFS_ENV_OFFSET    = 8'h18;
  localparam logic [7:0] OFS_FORCED_TC     = 8'h1c;
  localparam logic [7:0] OFS_ZERO_SPEED    = 8'h20;
  localparam logic [7:0] OFS_BRAKE_DELAY   = 8'h24;
  localparam logic [7:0] OFS_EBRAKE_TIME   = 8'h28;
  localparam logic [7:0] OFS_STATUS        = 8'h2c;

  // Configuration field positions
  localparam int CFG_DECEL_MON_POS    = 0;
  localparam int CFG_FORCED_DECEL_POS = 1;
  localparam int CFG_EBRAKE_SEL_POS   = 2;
  localparam int CFG_QUAL_MOTOR_POS   = 3;
  localparam int CFG_WIDTH            = 4;

  // Status field positions
  localparam int STS_ACTIVE_POS    = 0;
  localparam int STS_SHUTOFF_POS   = 1;
  localparam int STS_BRAKE_POS     = 2;
  localparam int STS_POWER_OFF_POS = 3;
  localparam int STS_METHOD_POS    = 4;
  localparam int STS_DONE_POS      = 6;
  localparam int STS_OVER_POS      = 7;

  // Reset values
  localparam logic [CFG_WIDTH-1:0] CONFIG_RESET = 4'h0;
  localparam logic [31:0] MON_TIME_RESET     = 32'h0003_d090;
  localparam logic [31:0] MON_DELAY_RESET    = 32'h0000_0000;
  localparam logic [31:0] STOP_SPEED_RESET   = 32'h0000_0032;
  localparam logic [31:0] DETECT_DELAY_RESET = 32'h0000_0fa0;
  localparam logic [31:0] ENV_TC_RESET       = 32'h0000_03e8;
  localparam logic [31:0] ENV_OFFSET_RESET   = 32'h0000_0064;
  localparam logic [31:0] FORCED_TC_RESET    = 32'h0000_0010;
  localparam logic [31:0] ZERO_SPEED_RESET   = 32'h0000_0032;
  localparam logic [31:0] BRAKE_DELAY_RESET  = 32'h0000_0064;
  localparam logic [31:0] EBRAKE_TIME_RESET  = 32'h0001_86a0;

  // Envelope decays by one eighth of itself per step
  localparam int ENV_DECAY_SHIFT = 3;

  // Stop method and sequencer state
  typedef enum logic [1:0] {
    DYNAMIC_BRAKE_STOP,
    ELECTRONIC_BRAKE_STOP,
    FORCED_DECEL_STOP
  } ssop_method_type;

  typedef enum logic {
    ST_RUN,
    ST_STOP
  } ssop_state_type;

endpackage

// [hw/ssop_sequencer.sv]
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
module ssop_sequencer
  import ssop_pkg::*;
#(
  parameter int SPEED_W = 16,
  parameter int TIME_W  = 32
) (
  // Clock and reset
  input  wire logic                      clk_in,
  input  wire logic                      resetn_in,
  // Register port
  input  wire logic [7:0]                addr_in,
  input  wire logic [31:0]               wr_data_in,
  input  wire logic                      wr_in,
  input  wire logic                      rd_in,
  output logic      [31:0]               rd_data_out,
  // Safety and drive inputs
  input  wire logic                      controlled_stop_cmd_n_in,
  input  wire logic                      alarm_in,
  input  wire logic                      alarm_brake_type_in,
  input  wire logic                      torque_mode_in,
  input  wire logic                      torque_transition_in,
  input  wire logic signed [SPEED_W-1:0] speed_cmd_in,
  input  wire logic signed [SPEED_W-1:0] speed_fb_in,
  // Stop outputs
  output logic                           safe_stop_one_active_out,
  output logic                           safe_torque_off_out,
  output logic                           power_stage_off_out,
  output logic                           dynamic_brake_out,
  output logic      [1:0]                stop_method_out,
  output logic signed [SPEED_W-1:0]      ramp_speed_out
);

  // Refuse widths the register port cannot serve
  if (SPEED_W < 4 || SPEED_W > 31 || TIME_W < 8 || TIME_W > 32) begin : g_bad_width
    $error("ssop_sequencer: SPEED_W or TIME_W out of range");
  end

  // Whole module state
  typedef struct packed {
    ssop_state_type         state;
    logic [CFG_WIDTH-1:0]   config_bits;
    logic [TIME_W-1:0]      mon_time;
    logic [TIME_W-1:0]      mon_delay;
    logic [SPEED_W-1:0]     stop_speed;
    logic [TIME_W-1:0]      detect_delay;
    logic [TIME_W-1:0]      env_tc;
    logic [SPEED_W-1:0]     env_offset;
    logic [TIME_W-1:0]      forced_tc;
    logic [SPEED_W-1:0]     zero_speed;
    logic [TIME_W-1:0]      brake_delay;
    logic [TIME_W-1:0]      ebrake_time;
    logic [31:0]            rd_data;
    logic                   active;
    logic                   torque_off;
    logic                   power_off;
    logic                   brake_on;
    ssop_method_type        method;
    logic                   ramp_neg;
    logic [SPEED_W-1:0]     ramp_mag;
    logic signed [SPEED_W-1:0] ramp_speed;
    logic [SPEED_W:0]       envelope;
    logic                   decel_done;
    logic                   overspeed;
    logic [TIME_W-1:0]      elapsed;
    logic [TIME_W-1:0]      done_cnt;
    logic [TIME_W-1:0]      over_cnt;
    logic [TIME_W-1:0]      env_cnt;
    logic [TIME_W-1:0]      ramp_cnt;
    logic [TIME_W-1:0]      brake_cnt;
  } ssop_regs_type;

  ssop_regs_type st;
  ssop_regs_type next_st;

  logic                  trigger;
  logic                  tq_mode;
  logic                  eb_ok;
  ssop_method_type       sel_method;
  logic [SPEED_W-1:0]    cmd_mag;
  logic [SPEED_W-1:0]    fb_mag;
  logic [TIME_W-1:0]     eb_limit;
  logic                  mon_open;

  // Magnitude of a signed speed
  function automatic logic [SPEED_W-1:0] mag(input logic signed [SPEED_W-1:0] v);
    mag = v[SPEED_W-1] ? SPEED_W'(-v) : SPEED_W'(v);
  endfunction

  // Saturating tick counter
  function automatic logic [TIME_W-1:0] tick(input logic [TIME_W-1:0] c);
    tick = (c == {TIME_W{1'b1}}) ? c : c + TIME_W'(1);
  endfunction

  // Stop method choice and helper terms
  always_comb begin
    trigger   = !controlled_stop_cmd_n_in || alarm_in;
    tq_mode   = torque_mode_in || torque_transition_in;
    eb_ok     = st.config_bits[CFG_EBRAKE_SEL_POS] && st.config_bits[CFG_QUAL_MOTOR_POS];
    cmd_mag   = mag(speed_cmd_in);
    fb_mag    = mag(speed_fb_in);
    eb_limit  = (st.mon_time < st.ebrake_time) ? st.mon_time : st.ebrake_time;
    mon_open  = st.config_bits[CFG_DECEL_MON_POS] && (st.elapsed >= st.mon_delay);
    if (st.config_bits[CFG_FORCED_DECEL_POS] && !tq_mode && !(alarm_in && alarm_brake_type_in)
        && controlled_stop_cmd_n_in == 1'b0) begin
      sel_method = FORCED_DECEL_STOP;
    end else if (st.config_bits[CFG_FORCED_DECEL_POS] && !tq_mode && !alarm_brake_type_in) begin
      sel_method = FORCED_DECEL_STOP;
    end else if (eb_ok) begin
      sel_method = ELECTRONIC_BRAKE_STOP;
    end else begin
      sel_method = DYNAMIC_BRAKE_STOP;
    end
  end

  // Next state
  always_comb begin
    next_st = st;
    next_st.rd_data = 32'h0000_0000;
    // Register writes
    if (wr_in) begin
      unique case (addr_in)
        OFS_CONFIG:       next_st.config_bits  = wr_data_in[CFG_WIDTH-1:0];
        OFS_MON_TIME:     next_st.mon_time     = wr_data_in[TIME_W-1:0];
        OFS_MON_DELAY:    next_st.mon_delay    = wr_data_in[TIME_W-1:0];
        OFS_STOP_SPEED:   next_st.stop_speed   = wr_data_in[SPEED_W-1:0];
        OFS_DETECT_DELAY: next_st.detect_delay = wr_data_in[TIME_W-1:0];
        OFS_ENV_TC:       next_st.env_tc       = wr_data_in[TIME_W-1:0];
        OFS_ENV_OFFSET:   next_st.env_offset   = wr_data_in[SPEED_W-1:0];
        OFS_FORCED_TC:    next_st.forced_tc    = wr_data_in[TIME_W-1:0];
        OFS_ZERO_SPEED:   next_st.zero_speed   = wr_data_in[SPEED_W-1:0];
        OFS_BRAKE_DELAY:  next_st.brake_delay  = wr_data_in[TIME_W-1:0];
        OFS_EBRAKE_TIME:  next_st.ebrake_time  = wr_data_in[TIME_W-1:0];
        default: ;
      endcase
    end
    // Register reads, answered in the next cycle
    if (rd_in) begin
      unique case (addr_in)
        OFS_CONFIG:       next_st.rd_data = 32'(st.config_bits);
        OFS_MON_TIME:     next_st.rd_data = 32'(st.mon_time);
        OFS_MON_DELAY:    next_st.rd_data = 32'(st.mon_delay);
        OFS_STOP_SPEED:   next_st.rd_data = 32'(st.stop_speed);
        OFS_DETECT_DELAY: next_st.rd_data = 32'(st.detect_delay);
        OFS_ENV_TC:       next_st.rd_data = 32'(st.env_tc);
        OFS_ENV_OFFSET:   next_st.rd_data = 32'(st.env_offset);
        OFS_FORCED_TC:    next_st.rd_data = 32'(st.forced_tc);
        OFS_ZERO_SPEED:   next_st.rd_data = 32'(st.zero_speed);
        OFS_BRAKE_DELAY:  next_st.rd_data = 32'(st.brake_delay);
        OFS_EBRAKE_TIME:  next_st.rd_data = 32'(st.ebrake_time);
        OFS_STATUS: begin
          next_st.rd_data[STS_ACTIVE_POS]    = st.active;
          next_st.rd_data[STS_SHUTOFF_POS]   = st.torque_off;
          next_st.rd_data[STS_BRAKE_POS]     = st.brake_on;
          next_st.rd_data[STS_POWER_OFF_POS] = st.power_off;
          next_st.rd_data[STS_METHOD_POS+:2] = st.method;
          next_st.rd_data[STS_DONE_POS]      = st.decel_done;
          next_st.rd_data[STS_OVER_POS]      = st.overspeed;
        end
        default:          next_st.rd_data = 32'h0000_0000;
      endcase
    end
    // Stop sequence
    unique case (st.state)
      ST_RUN: begin
        if (trigger) begin
          next_st.state      = ST_STOP;
          next_st.active     = 1'b1;
          next_st.method     = sel_method;
          next_st.brake_on   = (sel_method == DYNAMIC_BRAKE_STOP);
          next_st.torque_off = 1'b0;
          next_st.power_off  = 1'b0;
          next_st.elapsed    = '0;
          next_st.done_cnt   = '0;
          next_st.over_cnt   = '0;
          next_st.env_cnt    = '0;
          next_st.ramp_cnt   = '0;
          next_st.brake_cnt  = '0;
          next_st.decel_done = 1'b0;
          next_st.overspeed  = 1'b0;
          next_st.envelope   = {1'b0, fb_mag} + {1'b0, st.env_offset};
          next_st.ramp_neg   = speed_cmd_in[SPEED_W-1];
          next_st.ramp_mag   = cmd_mag;
          next_st.ramp_speed = speed_cmd_in;
        end
      end
      ST_STOP: begin
        if (!trigger) begin
          next_st.state      = ST_RUN;
          next_st.active     = 1'b0;
          next_st.torque_off = 1'b0;
          next_st.power_off  = 1'b0;
          next_st.brake_on   = 1'b0;
          next_st.ramp_speed = '0;
        end else begin
          next_st.elapsed = tick(st.elapsed);
          // Envelope decay, one step per time-constant period
          if (tick(st.env_cnt) >= st.env_tc) begin
            next_st.env_cnt  = '0;
            next_st.envelope = st.envelope - (st.envelope >> ENV_DECAY_SHIFT);
          end else begin
            next_st.env_cnt = tick(st.env_cnt);
          end
          // Forced deceleration ramp and brake sequence
          if (st.method == FORCED_DECEL_STOP) begin
            if (st.ramp_mag != '0) begin
              if (tick(st.ramp_cnt) >= st.forced_tc) begin
                next_st.ramp_cnt = '0;
                next_st.ramp_mag = st.ramp_mag - SPEED_W'(1);
              end else begin
                next_st.ramp_cnt = tick(st.ramp_cnt);
              end
            end else if (fb_mag <= st.zero_speed || st.power_off) begin
              next_st.power_off = 1'b1;
              next_st.brake_cnt = tick(st.brake_cnt);
              if (st.brake_cnt >= st.brake_delay) begin
                next_st.brake_on = 1'b1;
              end
            end
            next_st.ramp_speed = st.ramp_neg ? -$signed(next_st.ramp_mag)
                                             : $signed(next_st.ramp_mag);
          end
          // Electronic brake hands over to the dynamic brake
          if (st.method == ELECTRONIC_BRAKE_STOP && st.elapsed >= eb_limit) begin
            next_st.brake_on = 1'b1;
          end
          // Speed based monitoring after the delay
          if (mon_open) begin
            if (cmd_mag <= st.stop_speed && fb_mag <= st.stop_speed) begin
              next_st.decel_done = 1'b1;
            end
            if ({1'b0, fb_mag} > st.envelope) begin
              next_st.overspeed = 1'b1;
            end
          end
          if (st.decel_done) begin
            next_st.done_cnt = tick(st.done_cnt);
          end
          if (st.overspeed) begin
            next_st.over_cnt = tick(st.over_cnt);
          end
          // Torque shutoff causes
          if (st.elapsed >= st.mon_time
              || (st.decel_done && st.done_cnt >= st.detect_delay)
              || (st.overspeed && st.over_cnt >= st.detect_delay)) begin
            next_st.torque_off = 1'b1;
          end
          if (st.torque_off) begin
            next_st.power_off = 1'b1;
            next_st.brake_on  = 1'b1;
          end
        end
      end
    endcase
  end

  // State register with synchronous reset
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      st              <= '0;
      st.state        <= ST_RUN;
      st.method       <= DYNAMIC_BRAKE_STOP;
      st.config_bits  <= CONFIG_RESET;
      st.mon_time     <= TIME_W'(MON_TIME_RESET);
      st.mon_delay    <= TIME_W'(MON_DELAY_RESET);
      st.stop_speed   <= SPEED_W'(STOP_SPEED_RESET);
      st.detect_delay <= TIME_W'(DETECT_DELAY_RESET);
      st.env_tc       <= TIME_W'(ENV_TC_RESET);
      st.env_offset   <= SPEED_W'(ENV_OFFSET_RESET);
      st.forced_tc    <= TIME_W'(FORCED_TC_RESET);
      st.zero_speed   <= SPEED_W'(ZERO_SPEED_RESET);
      st.brake_delay  <= TIME_W'(BRAKE_DELAY_RESET);
      st.ebrake_time  <= TIME_W'(EBRAKE_TIME_RESET);
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign rd_data_out              = st.rd_data;
  assign safe_stop_one_active_out = st.active;
  assign safe_torque_off_out      = st.torque_off;
  assign power_stage_off_out      = st.power_off;
  assign dynamic_brake_out        = st.brake_on;
  assign stop_method_out          = st.method;
  assign ramp_speed_out           = st.ramp_speed;

  // Checks
  a_cmd_activates: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !controlled_stop_cmd_n_in |=> safe_stop_one_active_out)
    else $error("stop command low did not activate the stop");
  a_alarm_activates: assert property (@(posedge clk_in) disable iff (!resetn_in)
    alarm_in |=> safe_stop_one_active_out)
    else $error("alarm did not activate the stop");
  a_release_resumes: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (controlled_stop_cmd_n_in && !alarm_in) |=> !safe_stop_one_active_out && !safe_torque_off_out)
    else $error("stop not released after command returned high");
  a_shutoff_on_timeout: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (st.state == ST_STOP && trigger && st.elapsed >= st.mon_time) |=> safe_torque_off_out)
    else $error("monitor time elapsed without torque shutoff");
  a_shutoff_holds_brake: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (safe_torque_off_out && trigger) |=> power_stage_off_out && dynamic_brake_out)
    else $error("torque shutoff without power cut and brake");
  a_brake_immediate: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ($rose(safe_stop_one_active_out) && stop_method_out == DYNAMIC_BRAKE_STOP)
    |-> dynamic_brake_out)
    else $error("dynamic brake method did not brake at once");
  a_ebrake_handover: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (st.state == ST_STOP && trigger && st.method == ELECTRONIC_BRAKE_STOP
     && st.elapsed >= eb_limit) |=> dynamic_brake_out)
    else $error("electronic brake did not hand over to dynamic brake");
  a_no_forced_off: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (st.state == ST_RUN && trigger && !st.config_bits[CFG_FORCED_DECEL_POS])
    |=> stop_method_out != FORCED_DECEL_STOP)
    else $error("forced deceleration chosen while disabled");
  a_mon_gated: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (st.state == ST_STOP && !st.decel_done && !mon_open) |=> !st.decel_done)
    else $error("speed monitoring started before its delay");
  a_shutoff_has_cause: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $rose(safe_torque_off_out) |-> ($past(st.elapsed) >= $past(st.mon_time))
      || $past(st.decel_done) || $past(st.overspeed))
    else $error("torque shutoff with no cause");

  // Monitoring, ramp and timer checks
  a_done_latch: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (st.state == ST_STOP && trigger && mon_open && cmd_mag <= st.stop_speed
     && fb_mag <= st.stop_speed) |=> st.decel_done)
    else $error("speed below stop speed not judged complete");
  a_done_shutoff: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (st.state == ST_STOP && trigger && st.decel_done && st.done_cnt >= st.detect_delay)
    |=> safe_torque_off_out)
    else $error("completion delay elapsed without torque shutoff");
  a_over_shutoff: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (st.state == ST_STOP && trigger && st.overspeed && st.over_cnt >= st.detect_delay)
    |=> safe_torque_off_out)
    else $error("overspeed delay elapsed without torque shutoff");
  a_torque_no_ramp: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (st.state == ST_RUN && trigger && tq_mode) |=> stop_method_out != FORCED_DECEL_STOP)
    else $error("forced deceleration chosen in torque mode");
  a_ramp_power_cut: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (st.state == ST_STOP && trigger && st.method == FORCED_DECEL_STOP && st.ramp_mag == '0
     && fb_mag <= st.zero_speed) |=> power_stage_off_out)
    else $error("ramp at zero speed did not cut the power stage");
  a_ramp_early_off: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (st.state == ST_STOP && trigger && st.method == FORCED_DECEL_STOP
     && st.elapsed >= st.mon_time) |=> safe_torque_off_out)
    else $error("monitor time expired mid-ramp without torque shutoff");
  a_elapsed_ticks: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (st.state == ST_STOP && trigger && st.elapsed != '1)
    |=> st.elapsed == $past(st.elapsed) + TIME_W'(1))
    else $error("elapsed time did not advance by one tick");

endmodule // ssop_sequencer

// [verif/ssop_safety_ctrl.sv]
`timescale 1ns/1ps
module ssop_safety_ctrl (
  // Clock, reset and requests from the bench
  input  wire logic clk_in,
  input  wire logic resetn_in,
  input  wire logic stop_req_in,
  input  wire logic alarm_req_in,
  // Safety lines toward the sequencer
  output logic      controlled_stop_cmd_n_out,
  output logic      alarm_out
);
  // Command line idles high and is driven low to ask for a stop
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      controlled_stop_cmd_n_out <= 1'b1;
      alarm_out                 <= 1'b0;
    end else begin
      controlled_stop_cmd_n_out <= !stop_req_in;
      alarm_out                 <= alarm_req_in;
    end
  end
endmodule // ssop_safety_ctrl

// [verif/safe_stop_one_sequencer_tb.sv]
`timescale 1ns/1ps
module safe_stop_one_sequencer_tb;
  import ssop_pkg::*;
  logic               clk_in = 1'b0;
  logic               resetn_in, wr_s, rd_s, stop_req, alarm_req, cmd_n, alarm;
  logic               atype, tq, tr, active, toff, poff, brk, al;
  logic [7:0]         addr;
  logic [31:0]        wdata, rdata;
  logic signed [15:0] scmd, sfb, ramp, rs;
  logic [1:0]         meth, mth;
  int                 error_cnt, comparisons, seed, a0, ts, td, tp, i, r, cfg, eb, em;

  // Free running clock
  always #2 clk_in = ~clk_in;

  ssop_safety_ctrl i_ctrl (.clk_in(clk_in), .resetn_in(resetn_in), .stop_req_in(stop_req),
    .alarm_req_in(alarm_req), .controlled_stop_cmd_n_out(cmd_n), .alarm_out(alarm));

  ssop_sequencer i_dut (.clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr),
    .wr_data_in(wdata), .wr_in(wr_s), .rd_in(rd_s), .rd_data_out(rdata),
    .controlled_stop_cmd_n_in(cmd_n), .alarm_in(alarm), .alarm_brake_type_in(atype),
    .torque_mode_in(tq), .torque_transition_in(tr), .speed_cmd_in(scmd),
    .speed_fb_in(sfb), .safe_stop_one_active_out(active), .safe_torque_off_out(toff),
    .power_stage_off_out(poff), .dynamic_brake_out(brk), .stop_method_out(meth),
    .ramp_speed_out(ramp));

  task end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  // One-cycle register write and read
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk_in);
    wr_s  <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge clk_in);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_in);
    rd_s <= 1'b0;
    #1;
    chk(n, rdata, e);
  endtask

  // Request a stop, note when each output rises, then release
  task run(input logic alm);
    int k;
    a0 = -1;
    ts = -1;
    td = -1;
    tp = -1;
    if (alm) alarm_req <= 1'b1;
    else stop_req <= 1'b1;
    for (k = 0; k < 300; k++) begin
      @(posedge clk_in);
      #1;
      if (a0 < 0 && active === 1'b1) begin
        a0  = k;
        mth = meth;
      end
      if (a0 >= 0 && ts < 0 && toff === 1'b1) begin
        ts = k - a0;
        rs = ramp;
      end
      if (a0 >= 0 && td < 0 && brk === 1'b1) td = k - a0;
      if (a0 >= 0 && tp < 0 && poff === 1'b1) tp = k - a0;
    end
    if (a0 < 0) begin
      error_cnt++;
      end_sim();
    end
    stop_req  <= 1'b0;
    alarm_req <= 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
    // Captured method stays on its output after release; the rest clears
    chk("outputs after release", {active, toff, poff, brk, meth, ramp},
        {4'b0000, 2'(em), 16'h0000});
  endtask

  initial begin
    {resetn_in, wr_s, rd_s, stop_req, alarm_req, atype, tq, tr} = '0;
    {addr, wdata, scmd, sfb} = '0;
    seed = 99;
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'b1;
    rd(OFS_CONFIG, 32'h0, "config reset");
    rd(OFS_MON_TIME, MON_TIME_RESET, "monitor time reset");
    wr(OFS_MON_TIME, 32'h32);
    wr(OFS_MON_DELAY, 32'h5);
    wr(OFS_DETECT_DELAY, 32'h5);
    wr(OFS_ENV_TC, 32'h4);
    wr(OFS_FORCED_TC, 32'h1);
    wr(OFS_BRAKE_DELAY, 32'h5);
    wr(8'h30, 32'h55);
    rd(8'h30, 32'h0, "unmapped read");
    wr(OFS_STATUS, 32'hff);
    rd(OFS_STATUS, 32'h0, "status idle");
    rd(OFS_MON_TIME, 32'h32, "monitor time");
    $display("test registers done");
    // Random method table, time-only monitoring
    for (i = 0; i < 24; i++) begin
      r   = $random(seed);
      cfg = r & 14;
      eb  = r[8] ? 10 : 90;
      al  = r[7];
      wr(OFS_CONFIG, cfg);
      wr(OFS_EBRAKE_TIME, eb);
      tq    <= r[4];
      tr    <= r[5];
      atype <= r[6];
      scmd  <= 16'(r[15:9]);
      sfb   <= 16'h0;
      em = (cfg[1] && !(r[4] || r[5]) && !(al && r[6])) ? 2 : (cfg[2] && cfg[3]) ? 1 : 0;
      run(al);
      chk("method", mth, em);
      chk("shutoff time", ts, 51);
      if (em == 0) chk("brake time", td, 0);
      if (em == 1) chk("brake time", td, (eb < 50 ? eb : 50) + 1);
      if (em != 2) chk("power off time", tp, 52);
    end
    $display("test method table done");
    {tq, tr} <= 2'b00;
    scmd     <= 16'sd0;
    em       = 0;
    wr(OFS_CONFIG, 32'h1);
    run(1'b0);
    chk("completion shutoff", ts >= 10 && ts <= 16, 1);
    scmd <= 16'sd1000;
    sfb  <= 16'sd1000;
    run(1'b0);
    chk("overspeed shutoff", ts >= 6 && ts < 51, 1);
    wr(OFS_ENV_OFFSET, 32'h1000);
    wr(OFS_ENV_TC, 32'hffff);
    run(1'b0);
    chk("monitor time shutoff", ts, 51);
    $display("test monitoring done");
    wr(OFS_CONFIG, 32'h2);
    em = 2;
    scmd <= 16'sd20;
    sfb  <= 16'sd0;
    run(1'b0);
    chk("ramp power off", tp >= 19 && tp <= 24, 1);
    chk("brake after delay", td - tp >= 5 && td - tp <= 7, 1);
    wr(OFS_MON_TIME, 32'ha);
    scmd <= 16'sd40;
    run(1'b0);
    chk("early shutoff", ts, 11);
    chk("ramp still moving", rs != 0, 1);
    $display("test forced decel done");
    end_sim();
  end
endmodule // safe_stop_one_sequencer_tb
